// [bce_exec_consts.vh]
// Constants for the bit, call, clear and decrement execution block.
`ifndef BCE_EXEC_CONSTS_VH
`define BCE_EXEC_CONSTS_VH

// Register byte offsets on the bus.
`define BCE_ADR_INSTR      10'h000
`define BCE_ADR_WREG       10'h004
`define BCE_ADR_STATUS     10'h008
`define BCE_ADR_PC         10'h00c
`define BCE_ADR_UPPER_PC_LATCH     10'h010
`define BCE_ADR_TOS        10'h014
`define BCE_ADR_DEPTH      10'h018
`define BCE_ADR_FILE_BASE  10'h200

// Status field positions.
`define BCE_ST_Z           0
`define BCE_ST_PD          1
`define BCE_ST_TO          2
`define BCE_ST_BUSY        3
`define BCE_ST_SECOND      4

// Reset values.
`define BCE_RST_WREG       8'h00
`define BCE_RST_PC         13'h0000
`define BCE_RST_UPPER_PC_LATCH     5'h00
`define BCE_RST_Z          1'b0
`define BCE_RST_TO         1'b1
`define BCE_RST_PD         1'b1

// Opcode prefixes and full codes.
`define BCE_PFX_SETBIT     4'h5
`define BCE_PFX_TSTCLR     4'h6
`define BCE_PFX_TSTSET     4'h7
`define BCE_PFX_CALL       3'h4
`define BCE_PFX_CLEAR_FILE_REG       7'h03
`define BCE_PFX_CLEAR_ACCUMULATOR       7'h02
`define BCE_CODE_CLEAR_WATCHDOG_OP    14'h0064
`define BCE_PFX_INVERT     6'h09
`define BCE_PFX_DECSKIP    6'h0b

// Decoded operation classes.
`define BCE_OP_NOP         4'h0
`define BCE_OP_SETBIT      4'h1
`define BCE_OP_TSTCLR      4'h2
`define BCE_OP_TSTSET      4'h3
`define BCE_OP_CALL        4'h4
`define BCE_OP_CLEAR_FILE_REG        4'h5
`define BCE_OP_CLEAR_ACCUMULATOR        4'h6
`define BCE_OP_CLEAR_WATCHDOG_OP      4'h7
`define BCE_OP_INVERT      4'h8
`define BCE_OP_DECSKIP     4'h9

// Machine states and instruction-cycle phases.
`define BCE_S_IDLE         2'h0
`define BCE_S_EXEC         2'h1
`define BCE_S_NOPCYC       2'h2
`define BCE_Q1             2'h0
`define BCE_Q2             2'h1
`define BCE_Q3             2'h2
`define BCE_Q4             2'h3

`endif

// [bce_ret_stack.v]
// Circular hardware return stack for the execution block.
`timescale 1ns/10ps
module bce_ret_stack #(
   parameter DEPTH = 8,
   parameter PTR_W = 3,
   parameter DAT_W = 13
) (
   input  wire             clk_sys_i,
   input  wire             rst_n_i,
   input  wire             push_i,
   input  wire [DAT_W-1:0] data_i,
   output wire [DAT_W-1:0] top_o,
   output reg  [PTR_W:0]   fill_o
);

   reg [DAT_W-1:0] slot [0:DEPTH-1];
   reg [PTR_W-1:0] ptr;

   ////////////////////////////////////////////////////////////////////////
   // A full stack overwrites its oldest entry, as a circular buffer does.
   always @(posedge clk_sys_i) begin
      if (push_i) begin
         slot[ptr] <= data_i;
      end
   end

   always @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ptr    <= {PTR_W{1'b0}};
         fill_o <= {(PTR_W+1){1'b0}};
      end else if (push_i) begin
         ptr <= ptr + 1'b1;
         if (fill_o != DEPTH[PTR_W:0]) begin
            fill_o <= fill_o + 1'b1;
         end
      end
   end

   assign top_o = slot[ptr - 1'b1];

endmodule // bce_ret_stack

// [bce_exec_core.v]
// Execution unit for bit test/set, call, clear, complement and decrement-skip.
`timescale 1ns/10ps
`include "bce_exec_consts.vh"
module bce_exec_core #(
   parameter ADR_W       = 10,
   parameter FILE_N      = 128,
   parameter STACK_DEPTH = 8
) (
   input  wire             clk_sys_i,
   input  wire             rst_n_i,
   input  wire             wb_cyc_i,
   input  wire             wb_stb_i,
   input  wire             wb_we_i,
   input  wire [ADR_W-1:0] wb_adr_i,
   input  wire [3:0]       wb_sel_i,
   input  wire [31:0]      wb_dat_i,
   output reg  [31:0]      wb_dat_o,
   output reg              wb_ack_o,
   output wire             busy_o,
   output wire [1:0]       phase_o,
   output wire             second_cycle_o,
   output reg              wdt_clear_o,
   output reg              wdt_prescaler_clear_o
);

   ////////////////////////////////////////////////////////////////////////
   // Decode helpers.
   function [3:0] decode_op;
      input [13:0] ins;
      begin
         if (ins == `BCE_CODE_CLEAR_WATCHDOG_OP) begin
            decode_op = `BCE_OP_CLEAR_WATCHDOG_OP;
         end else if (ins[13:10] == `BCE_PFX_SETBIT) begin
            decode_op = `BCE_OP_SETBIT;
         end else if (ins[13:10] == `BCE_PFX_TSTCLR) begin
            decode_op = `BCE_OP_TSTCLR;
         end else if (ins[13:10] == `BCE_PFX_TSTSET) begin
            decode_op = `BCE_OP_TSTSET;
         end else if (ins[13:11] == `BCE_PFX_CALL) begin
            decode_op = `BCE_OP_CALL;
         end else if (ins[13:7] == `BCE_PFX_CLEAR_FILE_REG) begin
            decode_op = `BCE_OP_CLEAR_FILE_REG;
         end else if (ins[13:7] == `BCE_PFX_CLEAR_ACCUMULATOR) begin
            decode_op = `BCE_OP_CLEAR_ACCUMULATOR;
         end else if (ins[13:8] == `BCE_PFX_INVERT) begin
            decode_op = `BCE_OP_INVERT;
         end else if (ins[13:8] == `BCE_PFX_DECSKIP) begin
            decode_op = `BCE_OP_DECSKIP;
         end else begin
            decode_op = `BCE_OP_NOP;
         end
      end
   endfunction

   function [7:0] bit_mask;
      input [2:0] idx;
      begin
         bit_mask = 8'h01 << idx;
      end
   endfunction

   function [31:0] merge_lanes;
      input [31:0] old_v;
      input [31:0] new_v;
      input [3:0]  sel;
      integer      i;
      begin
         merge_lanes = old_v;
         for (i = 0; i < 4; i = i + 1) begin
            if (sel[i]) begin
               merge_lanes[i*8 +: 8] = new_v[i*8 +: 8];
            end
         end
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // State.
   reg  [7:0]  fmem [0:FILE_N-1];
   reg  [13:0] instr;
   reg  [3:0]  op;
   reg  [1:0]  state;
   reg  [1:0]  phase;
   reg  [7:0]  operand;
   reg  [7:0]  result;
   reg         skip;
   reg  [7:0]  wreg;
   reg  [12:0] pc;
   reg  [4:0]  upper_pc_latch;
   reg         flag_z;
   reg         flag_to;
   reg         flag_pd;
   wire [12:0] stack_top;
   wire [3:0]  depth;
   wire [6:0]  f_idx;
   wire [2:0]  b_idx;
   wire        dest_file;
   wire        acc;
   wire        bus_wr;
   wire        in_file;
   wire [6:0]  bus_fidx;
   wire        push;
   wire [31:0] pc_merged;
   wire [31:0] instr_merged;

   assign f_idx     = instr[6:0];
   assign b_idx     = instr[9:7];
   assign dest_file = instr[7];
   assign acc       = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign bus_wr    = acc & wb_we_i;
   assign in_file   = (wb_adr_i >= `BCE_ADR_FILE_BASE);
   assign bus_fidx  = wb_adr_i[8:2];
   assign pc_merged = merge_lanes({19'h00000, pc}, wb_dat_i, wb_sel_i);
   assign instr_merged = merge_lanes({18'h00000, instr}, wb_dat_i, wb_sel_i);

   assign busy_o         = (state != `BCE_S_IDLE);
   assign phase_o        = phase;
   assign second_cycle_o = (state == `BCE_S_NOPCYC);

   // Push in phase two, two edges before the program counter is written.
   assign push = (state == `BCE_S_EXEC) && (phase == `BCE_Q2)
                 && (op == `BCE_OP_CALL);

   bce_ret_stack #(
      .DEPTH (STACK_DEPTH),
      .PTR_W (3),
      .DAT_W (13)
   ) u_stack (
      .clk_sys_i (clk_sys_i),
      .rst_n_i   (rst_n_i),
      .push_i    (push),
      .data_i    (pc + 13'h0001),
      .top_o     (stack_top),
      .fill_o    (depth)
   );

   ////////////////////////////////////////////////////////////////////////
   // Phase sequencer.
   always @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state <= `BCE_S_IDLE;
         phase <= `BCE_Q1;
         instr <= 14'h0000;
         op    <= `BCE_OP_NOP;
      end else begin
         case (state)
            `BCE_S_IDLE: begin
               phase <= `BCE_Q1;
               if (bus_wr && !in_file && wb_adr_i == `BCE_ADR_INSTR && wb_sel_i[0]) begin
                  instr <= instr_merged[13:0];
                  state <= `BCE_S_EXEC;
               end
            end
            `BCE_S_EXEC: begin
               phase <= phase + 2'h1;
               if (phase == `BCE_Q1) begin
                  op <= decode_op(instr);
               end
               if (phase == `BCE_Q4) begin
                  if (skip || op == `BCE_OP_CALL) begin
                     state <= `BCE_S_NOPCYC;
                  end else begin
                     state <= `BCE_S_IDLE;
                  end
               end
            end
            `BCE_S_NOPCYC: begin
               phase <= phase + 2'h1;
               if (phase == `BCE_Q4) begin
                  state <= `BCE_S_IDLE;
               end
            end
            default: begin
               state <= `BCE_S_IDLE;
               phase <= `BCE_Q1;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Operand read in phase two and processing in phase three.
   always @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         operand <= 8'h00;
         result  <= 8'h00;
         skip    <= 1'b0;
      end else if (state == `BCE_S_EXEC) begin
         if (phase == `BCE_Q1) begin
            skip <= 1'b0;
         end
         if (phase == `BCE_Q2) begin
            case (op)
               `BCE_OP_SETBIT,
               `BCE_OP_TSTCLR,
               `BCE_OP_TSTSET,
               `BCE_OP_CLEAR_FILE_REG,
               `BCE_OP_INVERT,
               `BCE_OP_DECSKIP: operand <= fmem[f_idx];
               `BCE_OP_CALL:    operand <= instr[7:0];
               default:         operand <= operand;
            endcase
         end
         if (phase == `BCE_Q3) begin
            case (op)
               `BCE_OP_SETBIT:  result <= operand | bit_mask(b_idx);
               `BCE_OP_TSTCLR:  skip <= ~|(operand & bit_mask(b_idx));
               `BCE_OP_TSTSET:  skip <= |(operand & bit_mask(b_idx));
               `BCE_OP_INVERT:  result <= ~operand;
               `BCE_OP_DECSKIP: begin
                  result <= operand - 8'h01;
                  skip   <= (operand == 8'h01);
               end
               default:         result <= 8'h00;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Phase-four write back and bus writes while idle.
   always @(posedge clk_sys_i) begin
      if (state == `BCE_S_EXEC && phase == `BCE_Q4) begin
         case (op)
            `BCE_OP_SETBIT: fmem[f_idx] <= result;
            `BCE_OP_CLEAR_FILE_REG:   fmem[f_idx] <= 8'h00;
            `BCE_OP_INVERT,
            `BCE_OP_DECSKIP: begin
               if (dest_file) begin
                  fmem[f_idx] <= result;
               end
            end
            default: ;
         endcase
      end else if (state == `BCE_S_IDLE && bus_wr && in_file && wb_sel_i[0]) begin
         fmem[bus_fidx] <= wb_dat_i[7:0];
      end
   end

   always @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wreg    <= `BCE_RST_WREG;
         pc      <= `BCE_RST_PC;
         upper_pc_latch  <= `BCE_RST_UPPER_PC_LATCH;
         flag_z  <= `BCE_RST_Z;
         flag_to <= `BCE_RST_TO;
         flag_pd <= `BCE_RST_PD;
      end else if (state == `BCE_S_EXEC && phase == `BCE_Q4) begin
         if (op == `BCE_OP_CALL) begin
            pc <= {upper_pc_latch[4:3], instr[10:0]};
         end else begin
            pc <= pc + 13'h0001;
         end
         case (op)
            `BCE_OP_CLEAR_FILE_REG: flag_z <= 1'b1;
            `BCE_OP_CLEAR_ACCUMULATOR: begin
               wreg   <= 8'h00;
               flag_z <= 1'b1;
            end
            `BCE_OP_CLEAR_WATCHDOG_OP: begin
               flag_to <= 1'b1;
               flag_pd <= 1'b1;
            end
            `BCE_OP_INVERT: begin
               if (!dest_file) begin
                  wreg <= result;
               end
               flag_z <= (result == 8'h00);
            end
            `BCE_OP_DECSKIP: begin
               if (!dest_file) begin
                  wreg <= result;
               end
            end
            default: ;
         endcase
      end else if (state == `BCE_S_NOPCYC && phase == `BCE_Q4 && skip) begin
         // The discarded instruction still consumes its program address.
         pc <= pc + 13'h0001;
      end else if (state == `BCE_S_IDLE && bus_wr && !in_file) begin
         case (wb_adr_i)
            `BCE_ADR_WREG: begin
               if (wb_sel_i[0]) begin
                  wreg <= wb_dat_i[7:0];
               end
            end
            `BCE_ADR_PC: pc <= pc_merged[12:0];
            `BCE_ADR_UPPER_PC_LATCH: begin
               if (wb_sel_i[0]) begin
                  upper_pc_latch <= wb_dat_i[4:0];
               end
            end
            `BCE_ADR_STATUS: begin
               if (wb_sel_i[0]) begin
                  flag_z  <= wb_dat_i[`BCE_ST_Z];
                  flag_pd <= wb_dat_i[`BCE_ST_PD];
                  flag_to <= wb_dat_i[`BCE_ST_TO];
               end
            end
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Watchdog clear strobes stand for the whole of phase four.
   always @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wdt_clear_o           <= 1'b0;
         wdt_prescaler_clear_o <= 1'b0;
      end else begin
         wdt_clear_o           <= (state == `BCE_S_EXEC) && (phase == `BCE_Q3)
                                  && (op == `BCE_OP_CLEAR_WATCHDOG_OP);
         wdt_prescaler_clear_o <= (state == `BCE_S_EXEC) && (phase == `BCE_Q3)
                                  && (op == `BCE_OP_CLEAR_WATCHDOG_OP);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Bus answer: one wait state, read data registered with the ack.
   always @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= acc;
         if (acc && !wb_we_i) begin
            if (in_file) begin
               wb_dat_o <= {24'h000000, fmem[bus_fidx]};
            end else begin
               case (wb_adr_i)
                  `BCE_ADR_INSTR:  wb_dat_o <= {18'h00000, instr};
                  `BCE_ADR_WREG:   wb_dat_o <= {24'h000000, wreg};
                  `BCE_ADR_STATUS: wb_dat_o <= {27'h0000000, second_cycle_o, busy_o,
                                                flag_to, flag_pd, flag_z};
                  `BCE_ADR_PC:     wb_dat_o <= {19'h00000, pc};
                  `BCE_ADR_UPPER_PC_LATCH: wb_dat_o <= {27'h0000000, upper_pc_latch};
                  `BCE_ADR_TOS:    wb_dat_o <= {19'h00000, stack_top};
                  `BCE_ADR_DEPTH:  wb_dat_o <= {28'h0000000, depth};
                  default:         wb_dat_o <= 32'h00000000;
               endcase
            end
         end
      end
   end

endmodule // bce_exec_core

// [bce_exec_core_properties.sv]
// Port-level checker for the execution block.
`timescale 1ns/10ps
module bce_exec_core_props #(
   parameter ADR_W = 10
) (
   input logic             clk_sys_i,
   input logic             rst_n_i,
   input logic             wb_cyc_i,
   input logic             wb_stb_i,
   input logic             wb_we_i,
   input logic [ADR_W-1:0] wb_adr_i,
   input logic [3:0]       wb_sel_i,
   input logic [31:0]      wb_dat_i,
   input logic [31:0]      wb_dat_o,
   input logic             wb_ack_o,
   input logic             busy_o,
   input logic [1:0]       phase_o,
   input logic             second_cycle_o,
   input logic             wdt_clear_o,
   input logic             wdt_prescaler_clear_o
);
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!rst_n_i);

   AST_ACK_WAIT:
      assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("Bus request not answered after one wait state.");
   AST_ACK_PULSE:
      assert property (wb_ack_o |=> !wb_ack_o)
      else $error("Bus acknowledge longer than one cycle.");
   AST_PHASE_RUN:
      assert property ($rose(busy_o) |->
                       phase_o == 2'h0 ##1 phase_o == 2'h1 ##1 phase_o == 2'h2 ##1 phase_o == 2'h3)
      else $error("Phases did not run in order.");
   AST_IDLE_QUIET:
      assert property (!busy_o |-> phase_o == 2'h0 && !wdt_clear_o && !second_cycle_o)
      else $error("Activity while idle.");
   AST_ONE_CYCLE:
      assert property ($rose(busy_o) |-> busy_o [*4] ##1 (busy_o == second_cycle_o))
      else $error("Instruction cycle length wrong.");
   AST_WDT_Q4:
      assert property (wdt_clear_o |-> busy_o && phase_o == 2'h3 && !second_cycle_o)
      else $error("Watchdog clear outside phase four.");
   AST_WDT_PAIR:
      assert property (wdt_clear_o |-> wdt_prescaler_clear_o ##1
                       (!wdt_clear_o && !wdt_prescaler_clear_o))
      else $error("Watchdog and prescaler clear not one paired pulse.");
   AST_WDT_SAME:
      assert property (wdt_prescaler_clear_o == wdt_clear_o)
      else $error("Prescaler clear differs from watchdog clear.");
   AST_SECOND_LEN:
      assert property ($rose(second_cycle_o) |-> (second_cycle_o && busy_o) [*4] ##1
                       !second_cycle_o)
      else $error("Idle second cycle length wrong.");
   AST_SECOND_START:
      assert property ($rose(second_cycle_o) |-> $past(phase_o) == 2'h3 && $past(busy_o))
      else $error("Idle second cycle not after phase four.");

   cover property ($rose(second_cycle_o));
   cover property (wdt_clear_o);
   cover property ($rose(busy_o) ##4 !busy_o);
endmodule // bce_exec_core_props

// [test_bit_call_clear_decrement_exec.sv]
// Self-checking testbench for the bit, call, clear and decrement execution block.
`timescale 1ns/10ps
`include "bce_exec_consts.vh"
module test_bit_call_clear_decrement_exec;
   logic        clk_sys_i;
   logic        rst_n_i;
   logic        wb_cyc_i;
   logic        wb_stb_i;
   logic        wb_we_i;
   logic [9:0]  wb_adr_i;
   logic [3:0]  wb_sel_i;
   logic [31:0] wb_dat_i;
   wire  [31:0] wb_dat_o;
   wire         wb_ack_o;
   wire         busy_o;
   wire  [1:0]  phase_o;
   wire         second_cycle_o;
   wire         wdt_clear_o;
   wire         wdt_prescaler_clear_o;
   int          mismatches = 0;
   int          checked = 0;
   int          wdt_seen = 0;

   bce_exec_core i_dut (
      .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .busy_o(busy_o), .phase_o(phase_o),
      .second_cycle_o(second_cycle_o), .wdt_clear_o(wdt_clear_o),
      .wdt_prescaler_clear_o(wdt_prescaler_clear_o));

   initial begin
      clk_sys_i = 1'b0;
      forever #5 clk_sys_i = ~clk_sys_i;
   end

   always @(posedge clk_sys_i) begin
      if (wdt_clear_o === 1'b1) wdt_seen <= wdt_seen + 1;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d,
                      output logic [31:0] r);
      int n;
      n = 0;
      @(posedge clk_sys_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do begin
         @(posedge clk_sys_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      r = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
      if (n >= 50) chk(32'h0, 32'h1);
   endtask

   task automatic wr(input logic [9:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(1'b1, a, d, r);
   endtask

   task automatic rd_chk(input logic [9:0] a, input logic [31:0] exp);
      logic [31:0] r;
      bus(1'b0, a, 32'h0, r);
      chk(r, exp);
   endtask

   function automatic logic [9:0] fa(input logic [6:0] f);
      return 10'h200 + {1'b0, f, 2'b00};
   endfunction

   // Runs one instruction and checks its length in clocks and, except for calls, the advance of the PC.
   task automatic exec(input logic [13:0] ins, input int ncyc);
      logic [31:0] pc0;
      int          n;
      n = 0;
      bus(1'b0, `BCE_ADR_PC, 32'h0, pc0);
      wr(`BCE_ADR_INSTR, {18'h0, ins});
      while (busy_o === 1'b1 && n < 50) begin
         n++;
         @(posedge clk_sys_i);
      end
      chk(32'(n), 32'(ncyc));
      if (ins[13:11] != `BCE_PFX_CALL) rd_chk(`BCE_ADR_PC, pc0 + 32'(ncyc / 4));
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_setbit;
      wr(fa(7'd5), 32'h0a);
      wr(`BCE_ADR_STATUS, 32'h7);
      exec({`BCE_PFX_SETBIT, 3'd7, 7'd5}, 4);
      rd_chk(fa(7'd5), 32'h8a);
      rd_chk(`BCE_ADR_STATUS, 32'h7);
      $display("set bit done");
   endtask

   task automatic t_testskip;
      wr(fa(7'd9), 32'h02);
      for (int i = 0; i < 4; i++) begin
         exec({(i[1] ? `BCE_PFX_TSTCLR : `BCE_PFX_TSTSET), 2'b00, ~(i[0] ^ i[1]), 7'd9},
              i[0] ? 4 : 8);
         rd_chk(fa(7'd9), 32'h02);
      end
      $display("bit test skip done");
   endtask

   task automatic t_call;
      logic [4:0]  lat;
      logic [10:0] k;
      for (int j = 0; j < 2; j++) begin
         lat = j ? 5'h08 : 5'h18;
         k = j ? 11'h7ff : 11'h5a5;
         wr(`BCE_ADR_UPPER_PC_LATCH, {27'h0, lat});
         wr(`BCE_ADR_PC, 32'h0123);
         exec({`BCE_PFX_CALL, k}, 8);
         rd_chk(`BCE_ADR_TOS, 32'h0124);
         rd_chk(`BCE_ADR_DEPTH, 32'(j + 1));
         rd_chk(`BCE_ADR_PC, {19'h0, lat[4:3], k});
      end
      $display("call done");
   endtask

   task automatic t_clear;
      wr(fa(7'd127), 32'h5a);
      wr(`BCE_ADR_STATUS, 32'h6);
      exec({`BCE_PFX_CLEAR_FILE_REG, 7'd127}, 4);
      rd_chk(fa(7'd127), 32'h0);
      rd_chk(`BCE_ADR_STATUS, 32'h7);
      wr(`BCE_ADR_WREG, 32'h5a);
      wr(`BCE_ADR_STATUS, 32'h6);
      exec({`BCE_PFX_CLEAR_ACCUMULATOR, 7'h7f}, 4);
      rd_chk(`BCE_ADR_WREG, 32'h0);
      rd_chk(`BCE_ADR_STATUS, 32'h7);
      $display("clear done");
   endtask

   task automatic t_wdt;
      int w0;
      w0 = wdt_seen;
      wr(`BCE_ADR_STATUS, 32'h1);
      exec(`BCE_CODE_CLEAR_WATCHDOG_OP, 4);
      rd_chk(`BCE_ADR_STATUS, 32'h7);
      chk(32'(wdt_seen - w0), 32'h1);
      $display("watchdog clear done");
   endtask

   task automatic t_invert;
      wr(fa(7'd3), 32'hff);
      wr(`BCE_ADR_STATUS, 32'h6);
      exec({`BCE_PFX_INVERT, 1'b1, 7'd3}, 4);
      rd_chk(fa(7'd3), 32'h0);
      rd_chk(`BCE_ADR_STATUS, 32'h7);
      wr(`BCE_ADR_WREG, 32'h33);
      exec({`BCE_PFX_INVERT, 1'b0, 7'd3}, 4);
      rd_chk(`BCE_ADR_WREG, 32'hff);
      rd_chk(fa(7'd3), 32'h0);
      rd_chk(`BCE_ADR_STATUS, 32'h6);
      $display("invert done");
   endtask

   task automatic t_decskip;
      wr(fa(7'd6), 32'h02);
      wr(`BCE_ADR_STATUS, 32'h7);
      exec({`BCE_PFX_DECSKIP, 1'b1, 7'd6}, 4);
      rd_chk(fa(7'd6), 32'h01);
      exec({`BCE_PFX_DECSKIP, 1'b1, 7'd6}, 8);
      rd_chk(fa(7'd6), 32'h00);
      rd_chk(`BCE_ADR_STATUS, 32'h7);
      wr(`BCE_ADR_STATUS, 32'h6);
      exec({`BCE_PFX_DECSKIP, 1'b0, 7'd6}, 4);
      rd_chk(`BCE_ADR_WREG, 32'hff);
      rd_chk(fa(7'd6), 32'h00);
      rd_chk(`BCE_ADR_STATUS, 32'h6);
      $display("decrement skip done");
   endtask

   task automatic t_bus;
      rd_chk(`BCE_ADR_STATUS, 32'h6);
      rd_chk(`BCE_ADR_DEPTH, 32'h0);
      wr(10'h100, 32'h55);
      rd_chk(10'h100, 32'h0);
      $display("bus map done");
   endtask

   task end_sim;
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      rst_n_i = 1'b0;
      wb_cyc_i = 1'b0;
      wb_stb_i = 1'b0;
      wb_we_i = 1'b0;
      wb_adr_i = 10'h0;
      wb_sel_i = 4'hf;
      wb_dat_i = 32'h0;
      repeat (16) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      t_bus();
      t_setbit();
      t_testskip();
      t_call();
      t_clear();
      t_wdt();
      t_invert();
      t_decskip();
      end_sim();
   end

   // The whole run needs a few hundred clocks; this limit leaves ample margin.
   initial begin
      #200000;
      mismatches++;
      end_sim();
   end
endmodule // test_bit_call_clear_decrement_exec

bind bce_exec_core bce_exec_core_props #(.ADR_W(ADR_W)) i_props (
   .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .busy_o(busy_o), .phase_o(phase_o),
   .second_cycle_o(second_cycle_o), .wdt_clear_o(wdt_clear_o),
   .wdt_prescaler_clear_o(wdt_prescaler_clear_o));
